//--- hw/cmg_guard.sv
// cpu mode controller, memory partition guard, opcode fetch and power states
// What this block does
// [R1] five modes: boot, test, contactless, system, user
// [R2] privileged mode is three hidden sub-modes: boot, test, contactless
// [R3] before fuse, reset ends in test mode
// [R4] after fuse, reset ends in system mode
// [R5] system reaches all application resources; user only granted resources
// [R6] exception or interrupt: fixed vector, system/user
// [R7] eight configuration vectors enter contactless mode
// [R8] thirty-two system call vectors enter system
// [R9] rom split application and test regions
// [R10] eeprom reserves 128 bytes plus 0/1k/4k
// [R11] ram reserves 0 or 128 bytes
// [R12] test mode reaches every memory
// [R13] boot/contactless reach only reserved regions
// [R14] system/user reach application; user further gated
// [R15] coprocessor reaches its ram part and application eeprom
// [R16] coprocessor bypasses access rights checks
// [R17] every reset runs boot code first
// [R18] opcode from first, sometimes second byte
// [R19] idle and sleep states, sleep with clock stop
// [R20] denied access neither reads nor writes
`timescale 1ns/100ps
module cmg_guard
    import cmg_pkg::*;
#(
    parameter int EXC_W = 4,
    parameter logic [7:0] PREFIX_BYTE = 8'hA5
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic test_fuse_blown,
    input wire logic [1:0] cl_config,
    input wire logic wake_pin,
    input wire logic boot_done,
    input wire logic exc_req,
    input wire logic [EXC_W-1:0] exc_id,
    input wire logic exc_to_user,
    input wire logic svc_req,
    input wire logic [cmg_pkg::SVC_VEC_W-1:0] svc_id,
    input wire logic cfgv_req,
    input wire logic [cmg_pkg::CFG_VEC_W-1:0] cfgv_id,
    input wire logic clos_exit,
    input wire logic to_user_req,
    input wire logic perm_we,
    input wire logic [cmg_pkg::PERM_W-1:0] perm_wdata,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [1:0] cpu_sel,
    input wire logic [cmg_pkg::ADDR_W-1:0] cpu_addr,
    output logic cpu_ok,
    output logic cpu_fault_q,
    output logic cpu_rvalid_q,
    output logic [7:0] cpu_rdata_q,
    output logic mem_en,
    output logic mem_we,
    input wire logic [7:0] mem_rdata,
    input wire logic cop_req,
    input wire logic [1:0] cop_sel,
    input wire logic [cmg_pkg::ADDR_W-1:0] cop_addr,
    output logic cop_mem_en,
    output logic cop_fault,
    output cmg_pkg::cmg_mode_t mode_q,
    output logic jump_valid_q,
    output logic [cmg_pkg::ADDR_W-1:0] jump_addr_q,
    input wire logic op_valid,
    input wire logic [7:0] op_byte0,
    input wire logic [7:0] op_byte1,
    output logic op_long,
    output logic op_valid_q,
    output logic [15:0] op_code_q,
    input wire logic idle_req,
    input wire logic sleep_req,
    input wire logic stop_sel,
    output cmg_pkg::cmg_pwr_t pwr_q,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_en
);
    import cmg_pkg::*;

    generate
        if (EXC_W < 1 || EXC_W > 8) begin : g_bad_exc_w
            $error("EXC_W must lie in 1..8");
        end
    endgenerate

    // reset release through two flops
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // pin inputs pass two flops; only stage two is read
    logic [SYNC_W-1:0] pin_s1_q;
    logic [SYNC_W-1:0] pin_s2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {wake_pin, test_fuse_blown, cl_config};
            pin_s2_q <= pin_s1_q;
        end
    end

    // strap is caught once, after both synchroniser stages hold it;
    // changing it later must not move partitions
    logic [1:0] cfg_q;
    logic [1:0] cfg_wait_q;
    logic cfg_lock_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= CFG_4K;
            cfg_wait_q <= 2'h0;
            cfg_lock_q <= 1'b0;
        end else if (!cfg_lock_q) begin
            if (cfg_wait_q == 2'h2) begin
                cfg_q <= pin_s2_q[1:0]; // [R10] [R11]
                cfg_lock_q <= 1'b1;
            end else begin
                cfg_wait_q <= cfg_wait_q + 2'h1;
            end
        end
    end

    // partition boundaries for the captured configuration
    logic [ADDR_W-1:0] ee_res_end;
    logic [ADDR_W-1:0] ram_res_end;
    always_comb begin
        unique case (cfg_q)
            CFG_NONE: ee_res_end = EE_MFR; // [R10]
            CFG_1K: ee_res_end = EE_MFR + EE_CL_1K; // [R10]
            default: ee_res_end = EE_MFR + EE_CL_4K; // [R10]
        endcase
        ram_res_end = (cfg_q == CFG_NONE) ? '0 : RAM_CL; // [R11]
    end

    // user permissions; only system mode may change them
    logic [PERM_W-1:0] perm_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perm_q <= PERM_RST;
        end else if (perm_we && mode_q == MODE_SYSTEM) begin
            perm_q <= perm_wdata; // [R14]
        end
    end

    // cpu access check per mode
    logic in_range;
    logic rsv_hit;
    logic app_hit;
    logic user_ok;
    always_comb begin
        in_range = 1'b0;
        rsv_hit = 1'b0;
        app_hit = 1'b0;
        user_ok = 1'b0;
        unique case (cpu_sel)
            SEL_ROM: begin
                in_range = cpu_addr < ROM_SIZE;
                rsv_hit = in_range && cpu_addr >= ROM_APP_SIZE; // [R9]
                app_hit = cpu_addr < ROM_APP_SIZE; // [R9]
                user_ok = perm_q[PERM_ROM] && !cpu_we;
            end
            SEL_EE: begin
                in_range = cpu_addr < EE_SIZE;
                rsv_hit = cpu_addr < ee_res_end;
                app_hit = in_range && cpu_addr >= ee_res_end;
                user_ok = cpu_we ? perm_q[PERM_EE_WR] : perm_q[PERM_EE_RD];
            end
            SEL_RAM: begin
                in_range = cpu_addr < RAM_SIZE;
                rsv_hit = cpu_addr < ram_res_end;
                app_hit = in_range && cpu_addr >= ram_res_end; // [R15]
                user_ok = perm_q[PERM_RAM];
            end
            default: begin
                in_range = 1'b0;
            end
        endcase
        unique case (mode_q)
            MODE_TEST: cpu_ok = cpu_req && in_range; // [R12]
            MODE_BOOT, MODE_CLOS: cpu_ok = cpu_req && rsv_hit; // [R13]
            MODE_SYSTEM: cpu_ok = cpu_req && app_hit; // [R5] [R14]
            MODE_USER: cpu_ok = cpu_req && app_hit && user_ok; // [R5] [R14]
            default: cpu_ok = 1'b0;
        endcase
    end

    // a denied access never reaches the array
    assign mem_en = cpu_ok; // [R20]
    assign mem_we = cpu_ok && cpu_we; // [R20]

    // coprocessor: own ram and application eeprom, no mode check
    always_comb begin
        cop_mem_en = 1'b0;
        if (cop_req && cop_sel == SEL_RAM) begin
            cop_mem_en = cop_addr >= COP_RAM_BASE && cop_addr < RAM_SIZE; // [R15] [R16]
        end else if (cop_req && cop_sel == SEL_EE) begin
            cop_mem_en = cop_addr >= ee_res_end && cop_addr < EE_SIZE; // [R16]
        end
        cop_fault = cop_req && !cop_mem_en;
    end

    // read data returns two cycles after the request, zero when denied
    logic rd_pend_q;
    logic rd_ok_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_q <= 1'b0;
            rd_ok_q <= 1'b0;
            cpu_fault_q <= 1'b0;
            cpu_rvalid_q <= 1'b0;
            cpu_rdata_q <= 8'h00;
        end else begin
            rd_pend_q <= cpu_req && !cpu_we;
            rd_ok_q <= cpu_ok;
            cpu_fault_q <= cpu_req && !cpu_ok; // [R20]
            cpu_rvalid_q <= rd_pend_q;
            cpu_rdata_q <= (rd_pend_q && rd_ok_q) ? mem_rdata : 8'h00; // [R20]
        end
    end

    // mode transitions; exceptions outrank calls, calls outrank the drop to user
    logic app_mode;
    logic exc_take;
    logic svc_take;
    logic cfg_take;
    assign app_mode = mode_q == MODE_SYSTEM || mode_q == MODE_USER;
    assign exc_take = exc_req && (app_mode || mode_q == MODE_CLOS);
    assign svc_take = !exc_req && svc_req && app_mode;
    assign cfg_take = !exc_req && !svc_req && cfgv_req && app_mode;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_BOOT; // [R17] [R2]
        end else if (mode_q == MODE_BOOT) begin
            if (boot_done) begin
                mode_q <= pin_s2_q[2] ? MODE_SYSTEM : MODE_TEST; // [R3] [R4]
            end
        end else if (exc_take) begin
            mode_q <= exc_to_user ? MODE_USER : MODE_SYSTEM; // [R6]
        end else if (svc_take) begin
            mode_q <= MODE_SYSTEM; // [R8]
        end else if (cfg_take) begin
            mode_q <= MODE_CLOS; // [R7]
        end else if (mode_q == MODE_CLOS && clos_exit) begin
            mode_q <= MODE_SYSTEM;
        end else if (mode_q == MODE_SYSTEM && to_user_req) begin
            mode_q <= MODE_USER; // [R1]
        end
    end

    // fixed vector address for the taken entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            jump_valid_q <= 1'b0;
            jump_addr_q <= '0;
        end else begin
            jump_valid_q <= exc_take || svc_take || cfg_take;
            if (exc_take) begin
                jump_addr_q <= EXC_BASE + ADDR_W'({exc_id, 3'h0}); // [R6]
            end else if (svc_take) begin
                jump_addr_q <= SVC_VEC_BASE + ADDR_W'({svc_id, 3'h0}); // [R8]
            end else if (cfg_take) begin
                jump_addr_q <= CFG_VEC_BASE + ADDR_W'({cfgv_id, 3'h0}); // [R7]
            end
        end
    end

    // opcode: prefix byte pulls in the second byte
    assign op_long = op_byte0 == PREFIX_BYTE; // [R18]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_valid_q <= 1'b0;
            op_code_q <= 16'h0000;
        end else begin
            op_valid_q <= op_valid;
            if (op_valid) begin
                op_code_q <= op_long ? {op_byte0, op_byte1} : {8'h00, op_byte0}; // [R18]
            end
        end
    end

    // power states; only the synchronised wake pin leaves sleep or stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= PWR_RUN;
        end else begin
            unique case (pwr_q)
                PWR_RUN: begin
                    if (sleep_req) begin
                        pwr_q <= stop_sel ? PWR_STOP : PWR_SLEEP; // [R19]
                    end else if (idle_req) begin
                        pwr_q <= PWR_IDLE; // [R19]
                    end
                end
                PWR_IDLE: begin
                    if (exc_req || pin_s2_q[3]) begin
                        pwr_q <= PWR_RUN;
                    end
                end
                PWR_SLEEP, PWR_STOP: begin
                    if (pin_s2_q[3]) begin
                        pwr_q <= PWR_RUN;
                    end
                end
            endcase
        end
    end
    assign cpu_clk_en = pwr_q == PWR_RUN;
    assign periph_clk_en = pwr_q == PWR_RUN || pwr_q == PWR_IDLE;
    assign osc_en = pwr_q != PWR_STOP; // [R19]

    // checks
    sequence s_boot_exit;
        mode_q == MODE_BOOT && boot_done;
    endsequence
    sequence s_exc;
        exc_take;
    endsequence

    boot_holds_a: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        mode_q == MODE_BOOT && !boot_done |=> mode_q == MODE_BOOT)
        else $error("boot mode left without boot_done");
    boot_test_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        s_boot_exit ##0 !pin_s2_q[2] |=> mode_q == MODE_TEST)
        else $error("unfused reset did not end in test mode");
    boot_system_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        s_boot_exit ##0 pin_s2_q[2] |=> mode_q == MODE_SYSTEM)
        else $error("fused reset did not end in system mode");
    exc_vector_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        s_exc |=> jump_valid_q && jump_addr_q == EXC_BASE + ADDR_W'({$past(exc_id), 3'h0})
            && mode_q == ($past(exc_to_user) ? MODE_USER : MODE_SYSTEM))
        else $error("exception vector or mode wrong");
    cfg_vector_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        cfg_take |=> mode_q == MODE_CLOS && jump_valid_q)
        else $error("configuration vector did not enter contactless mode");
    svc_vector_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        svc_take |=> mode_q == MODE_SYSTEM && jump_valid_q)
        else $error("system call did not enter system mode");
    test_open_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        mode_q == MODE_TEST && cpu_req && (cpu_sel == SEL_ROM && cpu_addr < ROM_SIZE
            || cpu_sel == SEL_EE && cpu_addr < EE_SIZE
            || cpu_sel == SEL_RAM && cpu_addr < RAM_SIZE) |-> cpu_ok)
        else $error("test mode access refused");
    reserved_only_a: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        (mode_q == MODE_CLOS || mode_q == MODE_BOOT) && cpu_ok && cpu_sel == SEL_RAM
            |-> cpu_addr < ram_res_end)
        else $error("privileged mode reached application ram");
    denied_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
        cpu_req && !cpu_we && !cpu_ok |-> !mem_en ##1 cpu_fault_q ##1 cpu_rdata_q == 8'h00)
        else $error("denied read leaked data");
    cop_bypass_a: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        cop_req && cop_sel == SEL_RAM && cop_addr >= COP_RAM_BASE && cop_addr < RAM_SIZE
            |-> cop_mem_en)
        else $error("coprocessor ram access blocked");
    stop_osc_a: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
        pwr_q == PWR_RUN && sleep_req && stop_sel |=> !osc_en && !cpu_clk_en)
        else $error("clock stop did not stop oscillator");
endmodule

//--- hw/cmg_pkg.sv
// package: constants and types for the cpu mode and memory guard
package cmg_pkg;
    localparam int ADDR_W = 19;
    // memory selector codes
    localparam logic [1:0] SEL_ROM = 2'h0;
    localparam logic [1:0] SEL_EE = 2'h1;
    localparam logic [1:0] SEL_RAM = 2'h2;
    // contactless configuration strap codes
    localparam logic [1:0] CFG_NONE = 2'h0;
    localparam logic [1:0] CFG_1K = 2'h1;
    localparam logic [1:0] CFG_4K = 2'h2;
    // rom split: application part low, test part high
    localparam logic [ADDR_W-1:0] ROM_SIZE = 19'h48000;
    localparam logic [ADDR_W-1:0] ROM_APP_SIZE = 19'h42000;
    // eeprom: manufacturer area, then contactless reservation, then application
    localparam logic [ADDR_W-1:0] EE_SIZE = 19'h14000;
    localparam logic [ADDR_W-1:0] EE_MFR = 19'h00080;
    localparam logic [ADDR_W-1:0] EE_CL_1K = 19'h00400;
    localparam logic [ADDR_W-1:0] EE_CL_4K = 19'h01000;
    // ram: contactless reservation low, coprocessor ram at the top
    localparam logic [ADDR_W-1:0] RAM_SIZE = 19'h01E00;
    localparam logic [ADDR_W-1:0] RAM_CL = 19'h00080;
    localparam logic [ADDR_W-1:0] COP_RAM_SIZE = 19'h00A00;
    localparam logic [ADDR_W-1:0] COP_RAM_BASE = RAM_SIZE - COP_RAM_SIZE;
    // fixed vector table in application rom
    localparam logic [ADDR_W-1:0] EXC_BASE = 19'h00000;
    localparam logic [ADDR_W-1:0] CFG_VEC_BASE = 19'h00100;
    localparam logic [ADDR_W-1:0] SVC_VEC_BASE = 19'h00200;
    localparam int VEC_SHIFT = 3;
    localparam int CFG_VEC_W = 3;
    localparam int SVC_VEC_W = 5;
    // user permission bits: rom, eeprom read, eeprom write, ram
    localparam int PERM_W = 4;
    localparam int PERM_ROM = 0;
    localparam int PERM_EE_RD = 1;
    localparam int PERM_EE_WR = 2;
    localparam int PERM_RAM = 3;
    localparam logic [PERM_W-1:0] PERM_RST = 4'h1;
    localparam int SYNC_W = 4;

    typedef enum logic [2:0] {
        MODE_BOOT, MODE_TEST, MODE_CLOS, MODE_SYSTEM, MODE_USER
    } cmg_mode_t;

    typedef enum logic [1:0] {
        PWR_RUN, PWR_IDLE, PWR_SLEEP, PWR_STOP
    } cmg_pwr_t;
endpackage

//--- test/cmg_mem_model.sv
// memory array stand-in that answers the guard's strobes
`timescale 1ns/100ps
module cmg_mem_model (
    input wire logic clk,
    input wire logic mem_en,
    input wire logic mem_we,
    input wire logic [18:0] addr,
    output logic [7:0] rdata
);
    initial rdata = 8'h00;
    // the byte is a fixed function of the address, ready the cycle after the strobe;
    // when no read is granted the bus flips, so a stale byte never looks valid
    always @(posedge clk) begin
        if (mem_en && !mem_we) begin
            rdata <= addr[7:0] ^ 8'h3C;
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule

//--- test/cpu_mode_memory_guard_tb.sv
// self-checking bench for the cpu mode and memory guard
`timescale 1ns/100ps
module cpu_mode_memory_guard_tb;
    import cmg_pkg::*;
    logic clk, arst_n, test_fuse_blown, wake_pin, boot_done, exc_req, exc_to_user, svc_req;
    logic cfgv_req, clos_exit, to_user_req, perm_we, cpu_req, cpu_we, cop_req, op_valid;
    logic idle_req, sleep_req, stop_sel, cpu_ok, cpu_fault_q, cpu_rvalid_q, mem_en, mem_we;
    logic cop_mem_en, cop_fault, jump_valid_q, op_long, op_valid_q, cpu_clk_en, osc_en;
    logic periph_clk_en;
    logic [1:0] cl_config, cpu_sel, cop_sel;
    logic [3:0] exc_id, perm_wdata;
    logic [4:0] svc_id;
    logic [2:0] cfgv_id;
    logic [18:0] cpu_addr, cop_addr, jump_addr_q, a;
    logic [7:0] cpu_rdata_q, mem_rdata, op_byte0, op_byte1;
    logic [15:0] op_code_q;
    cmg_mode_t mode_q;
    cmg_pwr_t pwr_q;
    logic [7:0] rd_q[$];
    logic [18:0] jq[$];
    int n_errors, num_checks, seed, i;

    cmg_guard cmg_guard_inst (.clk(clk), .arst_n(arst_n), .test_fuse_blown(test_fuse_blown),
        .cl_config(cl_config), .wake_pin(wake_pin), .boot_done(boot_done), .exc_req(exc_req),
        .exc_id(exc_id), .exc_to_user(exc_to_user), .svc_req(svc_req), .svc_id(svc_id),
        .cfgv_req(cfgv_req), .cfgv_id(cfgv_id), .clos_exit(clos_exit), .to_user_req(to_user_req),
        .perm_we(perm_we), .perm_wdata(perm_wdata), .cpu_req(cpu_req), .cpu_we(cpu_we),
        .cpu_sel(cpu_sel), .cpu_addr(cpu_addr), .cpu_ok(cpu_ok), .cpu_fault_q(cpu_fault_q),
        .cpu_rvalid_q(cpu_rvalid_q), .cpu_rdata_q(cpu_rdata_q), .mem_en(mem_en), .mem_we(mem_we),
        .mem_rdata(mem_rdata), .cop_req(cop_req), .cop_sel(cop_sel), .cop_addr(cop_addr),
        .cop_mem_en(cop_mem_en), .cop_fault(cop_fault), .mode_q(mode_q),
        .jump_valid_q(jump_valid_q), .jump_addr_q(jump_addr_q), .op_valid(op_valid),
        .op_byte0(op_byte0), .op_byte1(op_byte1), .op_long(op_long), .op_valid_q(op_valid_q),
        .op_code_q(op_code_q), .idle_req(idle_req), .sleep_req(sleep_req), .stop_sel(stop_sel),
        .pwr_q(pwr_q), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .osc_en(osc_en));

    cmg_mem_model cmg_mem_model_inst (.clk(clk), .mem_en(mem_en), .mem_we(mem_we),
        .addr(cpu_addr), .rdata(mem_rdata));

    task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // reset, then let boot code finish once the fuse has crossed its synchroniser
    task automatic do_reset(input logic fuse, input logic [1:0] cfg);
        @(posedge clk);
        arst_n <= 1'b0;
        test_fuse_blown <= fuse;
        cl_config <= cfg;
        repeat (10) @(posedge clk);
        check("mode in reset", mode_q, MODE_BOOT);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        check("mode before boot end", mode_q, MODE_BOOT);
        boot_done <= 1'b1;
        @(posedge clk) boot_done <= 1'b0;
        #1 check("mode after boot", mode_q, fuse ? MODE_SYSTEM : MODE_TEST);
    endtask

    // one cpu byte access; grant is seen in the request cycle, fault one cycle later
    task automatic acc(input logic [1:0] sel, input logic [18:0] ad, input logic we,
                       input logic ok);
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_sel <= sel;
        cpu_addr <= ad;
        cpu_we <= we;
        #1 check("cpu grant", cpu_ok, ok);
        check("array write", mem_we, ok & we);
        @(posedge clk) cpu_req <= 1'b0;
        if (!we) rd_q.push_back(ok ? (ad[7:0] ^ 8'h3C) : 8'h00);
        #1 check("fault pulse", cpu_fault_q, !ok);
    endtask

    // kind: 0 exception, 1 system call, 2 configuration vector, 3 contactless exit, 4 drop
    task automatic vec(input int kind, input int id, input logic [18:0] base, input cmg_mode_t m);
        @(posedge clk);
        case (kind)
            0: begin exc_req <= 1'b1; exc_id <= id[3:0]; exc_to_user <= (m == MODE_USER); end
            1: begin svc_req <= 1'b1; svc_id <= id[4:0]; end
            2: begin cfgv_req <= 1'b1; cfgv_id <= id[2:0]; end
            3: clos_exit <= 1'b1;
            default: to_user_req <= 1'b1;
        endcase
        @(posedge clk) {exc_req, svc_req, cfgv_req, clos_exit, to_user_req} <= 5'h00;
        if (kind < 3) jq.push_back(base + 19'(id) * 19'h00008);
        #1 check("mode", mode_q, m);
    endtask

    task automatic cop(input logic [1:0] sel, input logic [18:0] ad, input logic ok);
        @(posedge clk);
        cop_req <= 1'b1;
        cop_sel <= sel;
        cop_addr <= ad;
        #1 check("cop grant", cop_mem_en, ok);
        check("cop refusal", cop_fault, !ok);
        @(posedge clk) cop_req <= 1'b0;
    endtask

    task automatic op(input logic [7:0] b0, input logic [7:0] b1, input logic [15:0] exp);
        @(posedge clk);
        op_valid <= 1'b1;
        op_byte0 <= b0;
        op_byte1 <= b1;
        #1 check("long flag", op_long, b0 == 8'hA5);
        @(posedge clk) op_valid <= 1'b0;
        #1 check("opcode", op_code_q, exp);
        check("opcode strobe", op_valid_q, 1'b1);
    endtask

    // enter a low power state, then wake through the pin within a bounded wait
    task automatic pwr(input logic slp, input logic stp, input cmg_pwr_t exp);
        @(posedge clk);
        sleep_req <= slp;
        idle_req <= !slp;
        stop_sel <= stp;
        @(posedge clk) {sleep_req, idle_req, stop_sel} <= 3'h0;
        #1 check("power state", pwr_q, exp);
        check("cpu clock", cpu_clk_en, 1'b0);
        check("oscillator", osc_en, exp != PWR_STOP);
        check("peripheral clock", periph_clk_en, exp == PWR_IDLE);
        @(posedge clk) wake_pin <= 1'b1;
        for (int k = 0; k < 8 && pwr_q !== PWR_RUN; k++) @(posedge clk);
        check("woken", pwr_q, PWR_RUN);
        @(posedge clk) wake_pin <= 1'b0;
    endtask

    // watchers take the oldest note whenever a result shows up
    always @(posedge clk) begin
        if (cpu_rvalid_q === 1'b1) begin
            if (rd_q.size() == 0) check("unexpected read", 19'h1, 19'h0);
            else check("read data", cpu_rdata_q, rd_q.pop_front());
        end
        if (jump_valid_q === 1'b1) begin
            if (jq.size() == 0) check("unexpected jump", 19'h1, 19'h0);
            else check("jump address", jump_addr_q, jq.pop_front());
        end
    end

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        {arst_n, test_fuse_blown, wake_pin, boot_done, exc_req, exc_to_user, svc_req} = '0;
        {cfgv_req, clos_exit, to_user_req, perm_we, cpu_req, cpu_we, cop_req, op_valid} = '0;
        {idle_req, sleep_req, stop_sel, cl_config, cpu_sel, cop_sel, exc_id, perm_wdata} = '0;
        {svc_id, cfgv_id, cpu_addr, cop_addr, op_byte0, op_byte1} = '0;
        seed = 37481;
        do_reset(1'b0, CFG_NONE);
        acc(SEL_ROM, 19'h47FFF, 1'b0, 1'b1);
        acc(SEL_RAM, 19'h00000, 1'b1, 1'b1);
        do_reset(1'b1, CFG_1K);
        acc(SEL_ROM, 19'h41FFF, 1'b0, 1'b1);
        acc(SEL_ROM, 19'h42000, 1'b0, 1'b0);
        acc(SEL_EE, 19'h0047F, 1'b0, 1'b0);
        acc(SEL_EE, 19'h00480, 1'b1, 1'b1);
        acc(SEL_RAM, 19'h0007F, 1'b0, 1'b0);
        acc(SEL_RAM, 19'h01DFF, 1'b0, 1'b1);
        for (i = 0; i < 32; i++) vec(1, i, SVC_VEC_BASE, MODE_SYSTEM);
        for (i = 0; i < 8; i++) begin
            vec(2, i, CFG_VEC_BASE, MODE_CLOS);
            if (i == 0) begin
                acc(SEL_EE, 19'h0047F, 1'b0, 1'b1);
                acc(SEL_EE, 19'h00480, 1'b0, 1'b0);
                acc(SEL_RAM, 19'h0007F, 1'b1, 1'b1);
                acc(SEL_ROM, 19'h42000, 1'b0, 1'b1);
                acc(SEL_ROM, 19'h00000, 1'b0, 1'b0);
            end
            vec(3, 0, EXC_BASE, MODE_SYSTEM);
        end
        vec(0, 5, EXC_BASE, MODE_USER);
        acc(SEL_ROM, 19'h00010, 1'b0, 1'b1);
        acc(SEL_RAM, 19'h00100, 1'b0, 1'b0);
        acc(SEL_ROM, 19'h00010, 1'b1, 1'b0);
        vec(0, 9, EXC_BASE, MODE_SYSTEM);
        @(posedge clk);
        perm_we <= 1'b1;
        perm_wdata <= 4'h8;
        @(posedge clk) perm_we <= 1'b0;
        vec(4, 0, EXC_BASE, MODE_USER);
        acc(SEL_RAM, 19'h00100, 1'b0, 1'b1);
        acc(SEL_ROM, 19'h00010, 1'b0, 1'b0);
        vec(1, 0, SVC_VEC_BASE, MODE_SYSTEM);
        for (i = 0; i < 24; i++) begin
            a = 19'($unsigned($random(seed)) % 32'd7680);
            acc(SEL_RAM, a, 1'b0, a >= RAM_CL);
        end
        cop(SEL_RAM, COP_RAM_BASE, 1'b1);
        cop(SEL_RAM, 19'h013FF, 1'b0);
        cop(SEL_EE, 19'h00480, 1'b1);
        cop(SEL_EE, 19'h0007F, 1'b0);
        cop(SEL_ROM, 19'h00000, 1'b0);
        op(8'hA5, 8'h12, 16'hA512);
        op(8'h3C, 8'h12, 16'h003C);
        pwr(1'b1, 1'b1, PWR_STOP);
        pwr(1'b1, 1'b0, PWR_SLEEP);
        pwr(1'b0, 1'b0, PWR_IDLE);
        do_reset(1'b1, CFG_4K);
        acc(SEL_EE, 19'h0107F, 1'b0, 1'b0);
        acc(SEL_EE, 19'h01080, 1'b0, 1'b1);
        acc(SEL_RAM, 19'h0007F, 1'b0, 1'b0);
        cop(SEL_EE, 19'h0107F, 1'b0);
        do_reset(1'b1, CFG_NONE);
        acc(SEL_EE, 19'h00080, 1'b0, 1'b1);
        acc(SEL_RAM, 19'h00000, 1'b0, 1'b1);
        repeat (4) @(posedge clk);
        check("pending notes", 19'(rd_q.size() + jq.size()), 19'h0);
        wrap_up();
    end
endmodule
